/* core/vgsr_pkg.sv */
// Constants shared by the general and sequencer register bank.
package vgsr_pkg;
	localparam logic [15:0] VGSR_PORT_MISC_WR = 16'h03c2;
	localparam logic [15:0] VGSR_PORT_MISC_RD = 16'h03cc;
	localparam logic [15:0] VGSR_PORT_STAT0 = 16'h03c2;
	localparam logic [15:0] VGSR_PORT_SEQ_IDX = 16'h03c4;
	localparam logic [15:0] VGSR_PORT_SEQ_DATA = 16'h03c5;
	localparam logic [15:0] VGSR_PORT_FEAT_RD = 16'h03ca;
	localparam logic [15:0] VGSR_PORT_STAT1_MONO = 16'h03ba;
	localparam logic [15:0] VGSR_PORT_STAT1_COLOR = 16'h03da;
	localparam logic [11:0] VGSR_CRT_BASE_MONO = 12'h03b;
	localparam logic [11:0] VGSR_CRT_BASE_COLOR = 12'h03d;
	localparam logic [2:0] VGSR_IDX_RESET = 3'h0;
	localparam logic [2:0] VGSR_IDX_CLOCKING = 3'h1;
	localparam logic [2:0] VGSR_IDX_MAP_MASK = 3'h2;
	localparam logic [2:0] VGSR_IDX_FONT_SEL = 3'h3;
	localparam logic [2:0] VGSR_IDX_MEM_MODE = 3'h4;
	localparam logic [7:0] VGSR_MISC_RESET = 8'h00;
	localparam logic [7:0] VGSR_FEAT_RESET = 8'h00;
	localparam logic [7:0] VGSR_SEQ_IDX_RESET = 8'h00;
	localparam logic [1:0] VGSR_SEQRST_RESET = 2'h0;
	localparam logic [5:0] VGSR_CLOCKING_RESET = 6'h00;
	localparam logic [3:0] VGSR_MAP_MASK_RESET = 4'h0;
	localparam logic [5:0] VGSR_FONT_SEL_RESET = 6'h00;
	localparam logic [2:0] VGSR_MEM_MODE_RESET = 3'h0;
	localparam logic [7:0] VGSR_MISC_MASK = 8'hef;
	localparam logic [7:0] VGSR_FEAT_MASK = 8'h08;
	localparam logic [7:0] VGSR_CLOCKING_MASK = 8'h3d;
	localparam logic [7:0] VGSR_MEM_MODE_MASK = 8'h0e;
	localparam int VGSR_MISC_EMU = 0;
	localparam int VGSR_MISC_RAM_EN = 1;
	localparam int VGSR_MISC_CLK_LO = 2;
	localparam int VGSR_MISC_PAGE = 5;
	localparam int VGSR_MISC_HPOL = 6;
	localparam int VGSR_MISC_VPOL = 7;
	localparam int VGSR_FEAT_VSEL = 3;
	localparam int VGSR_STAT0_SENSE = 4;
	localparam int VGSR_STAT0_IRQ = 7;
	localparam int VGSR_STAT1_DE = 0;
	localparam int VGSR_STAT1_VR = 3;
	localparam int VGSR_STAT1_DIAG = 4;
	localparam int VGSR_SEQ_ASYNC = 0;
	localparam int VGSR_SEQ_SYNC = 1;
	localparam int VGSR_CLK_DOT8 = 0;
	localparam int VGSR_CLK_SHL2 = 2;
	localparam int VGSR_CLK_DIV2 = 3;
	localparam int VGSR_CLK_SHL4 = 4;
	localparam int VGSR_CLK_SCR_OFF = 5;
	localparam int VGSR_MEM_EXT = 1;
	localparam logic [1:0] VGSR_VSIZE_RSVD = 2'b00;
	localparam logic [1:0] VGSR_VSIZE_400 = 2'b01;
	localparam logic [1:0] VGSR_VSIZE_350 = 2'b10;
	localparam logic [1:0] VGSR_VSIZE_480 = 2'b11;
	localparam logic [7:0] VGSR_NINTH_LO = 8'hc0;
	localparam logic [7:0] VGSR_NINTH_HI = 8'hdf;
	localparam logic [15:0] VGSR_FONT_STEP = 16'h2000;
	typedef enum logic [1:0] {
		VGSR_RELOAD_EVERY = 2'b00,
		VGSR_RELOAD_TWO = 2'b01,
		VGSR_RELOAD_FOUR = 2'b11
	} vgsr_reload_t;
endpackage

/* core/vgsr_regs.sv */
// General purpose and sequencer register bank of a VGA display controller.
`timescale 1ns/1ps
// Summary of operation
// - Misc bit 0 moves the CRT ports and status 1 between 3Bx/3BA and 3Dx/3DA.
// - Misc bit 1 clear blocks host decode of display memory.
// - Misc bits 3,2 drive the two clock select lines.
// - Misc bit 5 picks low or high 64 Kbyte page in odd/even modes.
// - Misc bits 6,7 set sync polarities and encode the vertical size.
// - Status 0 bit 4 returns the sense switch picked by clock select.
// - Status 0 bit 7 reads zero while retrace interrupt pends.
// - Status 1 bit 0 reads zero in active video, one in blanking.
// - Status 1 bit 3 reads one during vertical retrace.
// - Status 1 bits 5,4 return a pixel pair picked by the mux field.
// - Feature bit 3 ORs vertical display enable into vertical sync.
// - Sequencer index low three bits select the indexed data register.
// - Reset bit 0 clear halts sequencer at once; resets to zero.
// - Reset bit 1 clear halts sequencer at character boundary.
// - Clocking bit 0 picks nine or eight dot characters; ninth dot repeats for C0-DF.
// - Clocking bits 2 and 4 set serializer reload every one, two or four characters.
// - Clocking bit 3 divides the master clock by two for the dot clock.
// - Clocking bit 5 blanks the screen and gives the host full bandwidth.
// - Map mask bits gate host writes per plane.
// - Font select B from bits 4,1,0 gives an 8 K step offset in plane 2 only while fonts switch; otherwise the offset is zero.
// - Font select A from bits 5,3,2 uses the same offset encoding.
// - Attribute bit 3 switches fonts only if A differs from B and extended memory is set.
module vgsr_regs
	import vgsr_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	output logic io_hit,
	output logic crt_port_sel,
	input wire logic [3:0] sense_switch,
	input wire logic vretrace_irq_pending,
	input wire logic display_active,
	input wire logic vretrace,
	input wire logic vsync_in,
	input wire logic vdisp_enable,
	input wire logic [7:0] attr_pixel,
	input wire logic [1:0] video_status_mux,
	input wire logic mem_host_cycle,
	input wire logic [7:0] char_code,
	input wire logic attr_bit3,
	input wire logic [3:0] host_plane_wr,
	output logic mem_decode_en,
	output logic high_page_sel,
	output logic [1:0] clock_select_line,
	output logic hsync_neg,
	output logic vsync_neg,
	output logic [1:0] vertical_size,
	output logic vsync_out,
	output logic seq_run,
	output logic dot_clk_en,
	output logic char_clk_en,
	output logic nine_dot,
	output logic ninth_dot_repeat,
	output logic serial_reload,
	output logic screen_blank,
	output logic host_max_bandwidth,
	output logic [3:0] plane_wr_en,
	output logic full_width_write,
	output logic [15:0] font_offset
);
	logic [7:0] misc_output_control;
	logic [7:0] vsync_feature_control;
	logic [7:0] sequencer_index;
	logic [1:0] sequencer_reset_control;
	logic [5:0] dot_clocking_control;
	logic [3:0] plane_write_enable;
	logic [5:0] font_table_select;
	logic [2:0] plane_addressing_mode;
	logic [3:0] sense_meta, sense_sync;
	logic [3:0] misc_meta, misc_sync;
	logic [7:0] pix_meta, pix_sync;
	logic dot_phase;
	logic [3:0] dot_count;
	logic [1:0] reload_count;
	logic [7:0] next_io_rdata;

	// Asynchronous status inputs pass two flip-flops before use.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sense_meta <= 4'h0;
			sense_sync <= 4'h0;
			misc_meta <= 4'h0;
			misc_sync <= 4'h0;
			pix_meta <= 8'h00;
			pix_sync <= 8'h00;
		end else begin
			sense_meta <= sense_switch;
			sense_sync <= sense_meta;
			misc_meta <= {vretrace_irq_pending, display_active, vretrace, vdisp_enable};
			misc_sync <= misc_meta;
			pix_meta <= attr_pixel;
			pix_sync <= pix_meta;
		end
	end

	wire emu_color = misc_output_control[VGSR_MISC_EMU];
	wire [15:0] stat1_port = emu_color ? VGSR_PORT_STAT1_COLOR : VGSR_PORT_STAT1_MONO;
	wire [11:0] crt_base = emu_color ? VGSR_CRT_BASE_COLOR : VGSR_CRT_BASE_MONO;
	wire sel_crt = (io_addr[15:4] == crt_base);
	wire sel_misc_wr = io_wr && (io_addr == VGSR_PORT_MISC_WR);
	wire sel_feat_wr = io_wr && (io_addr == stat1_port);
	wire sel_idx = (io_addr == VGSR_PORT_SEQ_IDX);
	wire sel_data = (io_addr == VGSR_PORT_SEQ_DATA);
	wire [2:0] seq_sel = sequencer_index[2:0];
	wire wr_data = io_wr && sel_data;
	wire wr_reset = wr_data && (seq_sel == VGSR_IDX_RESET);
	wire wr_clocking = wr_data && (seq_sel == VGSR_IDX_CLOCKING);
	wire wr_mask = wr_data && (seq_sel == VGSR_IDX_MAP_MASK);
	wire wr_font = wr_data && (seq_sel == VGSR_IDX_FONT_SEL);
	wire wr_mem = wr_data && (seq_sel == VGSR_IDX_MEM_MODE);
	wire sync_dep = misc_sync[0];

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			misc_output_control <= VGSR_MISC_RESET;
			vsync_feature_control <= VGSR_FEAT_RESET;
			sequencer_index <= VGSR_SEQ_IDX_RESET;
		end else begin
			if (sel_misc_wr)
				misc_output_control <= io_wdata & VGSR_MISC_MASK;
			if (sel_feat_wr)
				vsync_feature_control <= io_wdata & VGSR_FEAT_MASK;
			if (io_wr && sel_idx)
				sequencer_index <= io_wdata;
		end
	end

	// Indexes 5 to 7 hold no register, so their writes fall through.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sequencer_reset_control <= VGSR_SEQRST_RESET;
			dot_clocking_control <= VGSR_CLOCKING_RESET;
			plane_write_enable <= VGSR_MAP_MASK_RESET;
			font_table_select <= VGSR_FONT_SEL_RESET;
			plane_addressing_mode <= VGSR_MEM_MODE_RESET;
		end else begin
			if (wr_reset)
				sequencer_reset_control <= io_wdata[1:0];
			if (wr_clocking)
				dot_clocking_control <= io_wdata[5:0] & VGSR_CLOCKING_MASK[5:0];
			if (wr_mask)
				plane_write_enable <= io_wdata[3:0];
			if (wr_font)
				font_table_select <= io_wdata[5:0];
			if (wr_mem)
				plane_addressing_mode <= io_wdata[3:1] & VGSR_MEM_MODE_MASK[3:1];
		end
	end

	// The async bit halts the counters without waiting for a boundary.
	wire seq_async_ok = sequencer_reset_control[VGSR_SEQ_ASYNC];
	wire seq_sync_ok = sequencer_reset_control[VGSR_SEQ_SYNC];
	vgsr_reload_t reload_mode;
	wire char_end = dot_clk_en && (dot_count == (nine_dot ? 4'h8 : 4'h7));
	wire reload_due = (reload_count == 2'h3) ||
		(reload_mode == VGSR_RELOAD_EVERY) ||
		((reload_mode == VGSR_RELOAD_TWO) && reload_count[0]);

	always_comb begin
		if (dot_clocking_control[VGSR_CLK_SHL4])
			reload_mode = VGSR_RELOAD_FOUR;
		else if (dot_clocking_control[VGSR_CLK_SHL2])
			reload_mode = VGSR_RELOAD_TWO;
		else
			reload_mode = VGSR_RELOAD_EVERY;
	end

	// The sync bit only stops the run at a character boundary.
	always_ff @(posedge mclk) begin
		if (!rst_n)
			seq_run <= 1'b0;
		else if (!seq_async_ok)
			seq_run <= 1'b0;
		else if (!seq_sync_ok && (char_end || !seq_run))
			seq_run <= 1'b0;
		else if (seq_sync_ok)
			seq_run <= 1'b1;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n || !seq_run)
			dot_phase <= 1'b0;
		else
			dot_phase <= ~dot_phase;
	end

	assign dot_clk_en = seq_run && (!dot_clocking_control[VGSR_CLK_DIV2] || dot_phase);
	assign nine_dot = !dot_clocking_control[VGSR_CLK_DOT8];

	always_ff @(posedge mclk) begin
		if (!rst_n || !seq_run) begin
			dot_count <= 4'h0;
			reload_count <= 2'h0;
		end else if (char_end) begin
			dot_count <= 4'h0;
			reload_count <= reload_due ? 2'h0 : reload_count + 2'h1;
		end else if (dot_clk_en) begin
			dot_count <= dot_count + 4'h1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			char_clk_en <= 1'b0;
			serial_reload <= 1'b0;
		end else begin
			char_clk_en <= char_end;
			serial_reload <= char_end && reload_due;
		end
	end

	assign ninth_dot_repeat = nine_dot && (char_code >= VGSR_NINTH_LO) &&
		(char_code <= VGSR_NINTH_HI);
	assign screen_blank = dot_clocking_control[VGSR_CLK_SCR_OFF];
	assign host_max_bandwidth = dot_clocking_control[VGSR_CLK_SCR_OFF] && mem_host_cycle;

	assign mem_decode_en = misc_output_control[VGSR_MISC_RAM_EN];
	assign high_page_sel = misc_output_control[VGSR_MISC_PAGE];
	assign clock_select_line = misc_output_control[VGSR_MISC_CLK_LO +: 2];
	assign hsync_neg = misc_output_control[VGSR_MISC_HPOL];
	assign vsync_neg = misc_output_control[VGSR_MISC_VPOL];
	assign vertical_size = {misc_output_control[VGSR_MISC_VPOL],
		misc_output_control[VGSR_MISC_HPOL]};
	assign crt_port_sel = sel_crt && (io_rd || io_wr);

	always_ff @(posedge mclk) begin
		if (!rst_n)
			vsync_out <= 1'b0;
		else if (vsync_feature_control[VGSR_FEAT_VSEL])
			vsync_out <= vsync_in | sync_dep;
		else
			vsync_out <= vsync_in;
	end

	assign plane_wr_en = plane_write_enable & host_plane_wr;
	assign full_width_write = &plane_write_enable;

	wire [2:0] font_b = {font_table_select[4], font_table_select[1:0]};
	wire [2:0] font_a = {font_table_select[5], font_table_select[3:2]};
	wire font_switch = (font_a != font_b) && plane_addressing_mode[0];
	wire [2:0] font_code = !font_switch ? 3'h0 : (attr_bit3 ? font_a : font_b);
	// Code bit 2 is the odd 8 K slot; bits 1,0 count 16 K steps.
	wire [15:0] font_step_idx = {13'h0000, font_code[1:0], font_code[2]};
	assign font_offset = 16'(font_step_idx * VGSR_FONT_STEP);

	wire [1:0] diag_bits = (video_status_mux == 2'b00) ? {pix_sync[2], pix_sync[0]} :
		(video_status_mux == 2'b01) ? {pix_sync[5], pix_sync[4]} :
		(video_status_mux == 2'b10) ? {pix_sync[3], pix_sync[1]} :
		{pix_sync[7], pix_sync[6]};
	wire sense_bit = sense_sync[clock_select_line];
	wire [7:0] stat0 = {~misc_sync[3], 2'b00, sense_bit, 4'h0};
	wire [7:0] stat1 = {2'b00, diag_bits, misc_sync[1], 2'b00, ~misc_sync[2]};
	wire [7:0] seq_rd = (seq_sel == VGSR_IDX_RESET) ? {6'h00, sequencer_reset_control} :
		(seq_sel == VGSR_IDX_CLOCKING) ? {2'b00, dot_clocking_control} :
		(seq_sel == VGSR_IDX_MAP_MASK) ? {4'h0, plane_write_enable} :
		(seq_sel == VGSR_IDX_FONT_SEL) ? {2'b00, font_table_select} :
		(seq_sel == VGSR_IDX_MEM_MODE) ? {4'h0, plane_addressing_mode, 1'b0} :
		8'h00;
	wire rd_hit = (io_addr == VGSR_PORT_MISC_RD) || (io_addr == VGSR_PORT_STAT0) ||
		(io_addr == VGSR_PORT_FEAT_RD) || (io_addr == stat1_port) || sel_idx || sel_data;

	assign next_io_rdata = (io_addr == VGSR_PORT_MISC_RD) ? misc_output_control :
		(io_addr == VGSR_PORT_STAT0) ? stat0 :
		(io_addr == VGSR_PORT_FEAT_RD) ? vsync_feature_control :
		(io_addr == stat1_port) ? stat1 :
		sel_idx ? {5'h00, sequencer_index[2:0]} :
		sel_data ? seq_rd : 8'h00;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			io_rdata <= 8'h00;
			io_hit <= 1'b0;
		end else begin
			io_rdata <= io_rd ? next_io_rdata : 8'h00;
			io_hit <= io_rd && rd_hit;
		end
	end
endmodule

/* test/vgsr_host_model.sv */
// Host CPU model issuing one-cycle I/O strobes to the register bank.
`timescale 1ns/1ps
module vgsr_host_model (
	input wire logic mclk,
	output logic [15:0] io_addr,
	output logic io_wr,
	output logic io_rd,
	output logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata,
	input wire logic io_hit
);
	initial begin
		io_addr = 16'h0000;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 8'h00;
	end
	// Released lines show the inverse so a stale value never reads as valid.
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(negedge mclk);
		io_addr = a;
		io_wdata = v;
		io_wr = 1'b1;
		@(negedge mclk);
		io_wr = 1'b0;
		io_addr = ~a;
		io_wdata = ~v;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] v, output logic h);
		@(negedge mclk);
		io_addr = a;
		io_rd = 1'b1;
		@(negedge mclk);
		io_rd = 1'b0;
		io_addr = ~a;
		v = io_rdata;
		h = io_hit;
	endtask
endmodule

/* test/vgsr_regs_sva.sv */
// Concurrent checks on the register bank ports.
`timescale 1ns/1ps
module vgsr_regs_sva (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata,
	input wire logic io_hit,
	input wire logic crt_port_sel,
	input wire logic [1:0] clock_select_line,
	input wire logic mem_decode_en,
	input wire logic high_page_sel,
	input wire logic hsync_neg,
	input wire logic vsync_neg,
	input wire logic [1:0] vertical_size,
	input wire logic seq_run,
	input wire logic nine_dot,
	input wire logic ninth_dot_repeat,
	input wire logic [7:0] char_code,
	input wire logic [3:0] host_plane_wr,
	input wire logic [3:0] plane_wr_en,
	input wire logic full_width_write,
	input wire logic screen_blank,
	input wire logic mem_host_cycle,
	input wire logic host_max_bandwidth
);
	logic [7:0] wd_q;
	logic emu_q;
	always_ff @(posedge mclk) begin
		wd_q <= io_wdata;
	end
	// Tracks the emulation bit of the last misc write to know where the CRT ports sit.
	always_ff @(posedge mclk) begin
		if (!rst_n)
			emu_q <= 1'b0;
		else if (io_wr && io_addr == 16'h03c2)
			emu_q <= io_wdata[0];
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	sequence s_idx0;
		io_wr && io_addr == 16'h03c4 && io_wdata[2:0] == 3'h0;
	endsequence
	sequence s_halt;
		io_wr && io_addr == 16'h03c5 && !io_wdata[0];
	endsequence
	misc_write_a: assert property (io_wr && io_addr == 16'h03c2 |=>
		{clock_select_line, high_page_sel, mem_decode_en} == {wd_q[3:2], wd_q[5], wd_q[1]})
		else $error("misc outputs differ from written value");
	vert_size_a: assert property (vertical_size == {vsync_neg, hsync_neg})
		else $error("vertical size differs from polarities");
	crt_sel_a: assert property (crt_port_sel == ((io_rd || io_wr) &&
		io_addr[15:4] == (emu_q ? 12'h03d : 12'h03b))) else $error("bad crt select");
	async_halt_a: assert property (s_idx0 ##2 s_halt |=> ##1 !seq_run)
		else $error("sequencer still running");
	ninth_dot_a: assert property (ninth_dot_repeat ==
		(nine_dot && char_code >= 8'hc0 && char_code <= 8'hdf)) else $error("ninth dot wrong");
	host_bandwidth_a: assert property (host_max_bandwidth == (screen_blank && mem_host_cycle))
		else $error("bandwidth grant wrong");
	plane_gate_a: assert property (full_width_write |-> plane_wr_en == host_plane_wr)
		else $error("plane gate wrong");
	idx_hit_a: assert property (io_rd && io_addr == 16'h03c4 |=> io_hit && io_rdata[7:3] == 5'h00)
		else $error("index read wrong");
	unmapped_read_a: assert property (io_rd && io_addr == 16'h0300 |=> !io_hit && io_rdata == 8'h00)
		else $error("unmapped read answered");
	idle_read_a: assert property (!io_rd |=> io_rdata == 8'h00)
		else $error("read data without read");
endmodule
bind vgsr_regs vgsr_regs_sva vgsr_regs_sva_i (.*);

/* test/tb.sv */
// Self-checking bench for the general and sequencer register bank.
`timescale 1ns/1ps
module tb;
	import vgsr_pkg::*;
	logic mclk = 0, rst_n = 0, io_wr, io_rd, io_hit, crt_port_sel, h, vretrace_irq_pending = 1;
	logic display_active = 0, vretrace = 1, vsync_in = 0, vdisp_enable = 1, mem_host_cycle = 1;
	logic attr_bit3 = 0, mem_decode_en, high_page_sel, hsync_neg, vsync_neg, vsync_out, seq_run;
	logic dot_clk_en, char_clk_en, nine_dot, ninth_dot_repeat, serial_reload, screen_blank;
	logic host_max_bandwidth, full_width_write, crt_q;
	logic [15:0] io_addr, font_offset;
	logic [7:0] io_wdata, io_rdata, d, attr_pixel = 8'ha5, char_code = 8'hc5;
	logic [3:0] sense_switch = 4'h1, host_plane_wr = 4'hf, plane_wr_en;
	logic [1:0] video_status_mux = 2'h0, clock_select_line, vertical_size;
	logic [1:0] mux_exp [4] = '{2'h3, 2'h2, 2'h0, 2'h2};
	logic [7:0] seq_mask [6] = '{8'h03, 8'h3d, 8'h0f, 8'h3f, 8'h0e, 8'h00};
	logic [7:0] ck_cfg [3] = '{8'h01, 8'h05, 8'h19};
	logic [23:0] ck_exp [3] = '{24'h801010, 24'h801008, 24'h400802};
	int error_cnt = 0, samples_checked = 0, cyc = 0;
	vgsr_regs vgsr_regs_i (.*);
	vgsr_host_model vgsr_host_model_i (.*);
	initial forever #20 mclk = ~mclk;
	// Captures the CRT select strobe in the cycle of each read.
	always @(posedge mclk) begin
		if (io_rd)
			crt_q <= crt_port_sel;
	end
	task finish_test;
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			finish_test();
		end
	end
	task chk(input logic [23:0] got, input logic [23:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task w(input logic [15:0] a, input logic [7:0] v);
		vgsr_host_model_i.wr(a, v);
	endtask
	task r(input logic [15:0] a);
		vgsr_host_model_i.rd(a, d, h);
	endtask
	task sw(input logic [2:0] i, input logic [7:0] v);
		w(VGSR_PORT_SEQ_IDX, {5'h00, i});
		w(VGSR_PORT_SEQ_DATA, v);
	endtask
	task t_misc;
		w(16'h03c2, 8'hed);
		chk({clock_select_line, high_page_sel, mem_decode_en}, 4'he);
		chk(vertical_size, VGSR_VSIZE_480);
		r(16'h03cc);
		chk(d, 8'hed);
		r(16'h03da);
		chk(h, 1'b1);
		r(16'h03d4);
		chk({h, crt_q}, 2'h1);
		w(16'h03c2, 8'h42);
		r(16'h03d4);
		chk({h, crt_q}, 2'h0);
		r(16'h03b5);
		chk({h, crt_q}, 2'h1);
		r(16'h03da);
		chk({h, vertical_size, mem_decode_en}, 4'h3);
	endtask
	task t_stat;
		r(16'h03c2);
		chk({d[7], d[4]}, 2'h1);
		vretrace_irq_pending = 1'b0;
		sense_switch = 4'h2;
		repeat (4) @(negedge mclk);
		r(16'h03c2);
		chk({d[7], d[4]}, 2'h2);
		r(16'h03ba);
		chk({d[3], d[0]}, 2'h3);
		display_active = 1'b1;
		vretrace = 1'b0;
		for (int i = 0; i < 4; i++) begin
			video_status_mux = 2'(i);
			repeat (4) @(negedge mclk);
			r(16'h03ba);
			chk({d[5:0] & 6'h39}, {mux_exp[i], 4'h0});
		end
	endtask
	task t_seq;
		for (int i = 5; i >= 0; i--) begin
			sw(3'(i), 8'hff);
			r(VGSR_PORT_SEQ_DATA);
			chk(d, seq_mask[i]);
		end
		w(VGSR_PORT_SEQ_IDX, 8'hfd);
		r(VGSR_PORT_SEQ_IDX);
		chk(d, 8'h05);
		chk(seq_run, 1'b1);
		sw(0, 8'h01);
		repeat (40) @(negedge mclk);
		chk(seq_run, 1'b0);
		sw(0, 8'h03);
		sw(0, 8'h02);
		@(negedge mclk);
		chk(seq_run, 1'b0);
		sw(2, 8'h05);
		chk({full_width_write, plane_wr_en}, 5'h05);
		sw(3, 8'h0d);
		chk(font_offset, 16'h4000);
		attr_bit3 = 1'b1;
		repeat (2) @(negedge mclk);
		chk(font_offset, 16'hc000);
		attr_bit3 = 1'b0;
		sw(3, 8'h10);
		chk(font_offset, 16'h2000);
		sw(4, 8'h00);
		chk(font_offset, 16'h0000);
	endtask
	task t_clk;
		int cd, cc, cr;
		for (int k = 0; k < 3; k++) begin
			sw(0, 8'h01);
			sw(1, ck_cfg[k]);
			sw(0, 8'h03);
			repeat (40) @(negedge mclk);
			{cd, cc, cr} = '0;
			repeat (128) begin
				@(negedge mclk);
				cd += dot_clk_en;
				cc += char_clk_en;
				cr += serial_reload;
			end
			chk({cd[7:0], cc[7:0], cr[7:0]}, ck_exp[k]);
		end
		sw(0, 8'h01);
		sw(1, 8'h21);
		chk({screen_blank, host_max_bandwidth}, 2'h3);
		sw(1, 8'h00);
		chk({nine_dot, ninth_dot_repeat, screen_blank}, 3'h6);
	endtask
	task t_feat;
		w(16'h03ba, 8'h08);
		repeat (4) @(negedge mclk);
		chk(vsync_out, 1'b1);
		r(16'h03ca);
		chk(d, 8'h08);
		w(16'h03ba, 8'h00);
		repeat (4) @(negedge mclk);
		chk(vsync_out, 1'b0);
		r(16'h0300);
		chk({h, d}, 9'h000);
	endtask
	initial begin
		repeat (5) @(negedge mclk);
		rst_n = 1'b1;
		t_misc();
		t_stat();
		t_seq();
		t_clk();
		t_feat();
		finish_test();
	end
endmodule
